// ---- asr_pkg.sv ----
// Shared constants for the secondary receive latch and clock source block
package asr_pkg;
  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SEC_RX_CFG   = 8'h26;
  localparam logic [7:0] IDX_RX_STATUS    = 8'h27;
  localparam logic [7:0] IDX_CLK_SRC      = 8'h32;
  localparam logic [7:0] IDX_SEC_BCLK_SRC = 8'h33;
  localparam int         ADR_W            = 10;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SEC_RX_CFG   = 8'h00;
  localparam logic [7:0] RST_CLK_SRC      = 8'h00;
  localparam logic [7:0] RST_SEC_BCLK_SRC = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RX_EDGE_BIT      = 7;
  localparam int RX_INT_FRAME_BIT = 6;
  localparam int RX_INT_BCLK_BIT  = 5;
  localparam int RX_OFS_MSB       = 4;
  localparam int RX_OFS_LSB       = 0;
  localparam int PREDIV_MSB       = 7;
  localparam int PREDIV_LSB       = 6;
  localparam int PRIDIV_MSB       = 5;
  localparam int PRIDIV_LSB       = 3;
  localparam int SECDIV_MSB       = 6;
  localparam int SECDIV_LSB       = 4;
  localparam int ST_OVERRUN_BIT   = 0;
  localparam int ST_AVAIL_BIT     = 1;
  localparam int ST_BUSY_BIT      = 2;
  // ----------------------------------------------------------------
  // Source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PREDIV_PRI_BCLK = 2'h0;
  localparam logic [1:0] PREDIV_SEC_BCLK = 2'h1;
  localparam logic [1:0] PREDIV_CTRL_CLK = 2'h2;
  localparam logic [1:0] PREDIV_OSC      = 2'h3;
  localparam logic [2:0] PRIDIV_PLL      = 3'h0;
  localparam logic [2:0] PRIDIV_SEC_BCLK = 3'h2;
  localparam logic [2:0] PRIDIV_CTRL_CLK = 3'h3;
  localparam logic [2:0] PRIDIV_OSC      = 3'h4;
  localparam logic [2:0] PRIDIV_DSP      = 3'h5;
  // ----------------------------------------------------------------
  // Receive framing
  // ----------------------------------------------------------------
  localparam int         WORD_BITS  = 32;
  localparam logic [4:0] LAST_BIT   = 5'h1F;
  localparam int         FIFO_DEPTH = 16;
  typedef enum logic [1:0] {RX_IDLE, RX_SKIP, RX_SHIFT} asr_rx_e;
endpackage : asr_pkg

// ---- asr_rx_latch_and_clock_mux.sv ----
// FIFO and top of the secondary receive latch and clock source block
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: Latch edge bit inverts default polarity edge
// R2: Controller mode: frame select picks internal sync
// R3: Controller mode: clock select picks internal bitclock
// R4: Slot 0 MSB delayed by offset bitclocks
// R5: Offset on both pins, left and right
// R6: Two-bit field picks PLL pre-divider source
// R7: Three-bit field picks primary divider source
// R8: Reserved low clock bits read zero
// R9: Host changes sources only while idle; the block does not check this and takes a source write at any time

module asr_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             oValid_q, oValid_d;
  logic [WIDTH-1:0] oData_q, oData_d;
  logic             push, pop;

  assign inReady  = (cnt_q != DEPTH[PW:0]);
  assign outValid = oValid_q;
  assign outData  = oData_q;

  always_comb begin
    push     = inValid && inReady;
    pop      = (cnt_q != '0) && (!oValid_q || outReady);
    wp_d     = push ? wp_q + 1'b1 : wp_q;
    rp_d     = pop ? rp_q + 1'b1 : rp_q;
    cnt_d    = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    oData_d  = pop ? mem[rp_q] : oData_q;
    oValid_d = pop ? 1'b1 : (outReady ? 1'b0 : oValid_q);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wp_q     <= '0;
      rp_q     <= '0;
      cnt_q    <= '0;
      oValid_q <= 1'b0;
      oData_q  <= '0;
    end else begin
      wp_q     <= wp_d;
      rp_q     <= rp_d;
      cnt_q    <= cnt_d;
      oValid_q <= oValid_d;
      oData_q  <= oData_d;
    end
  end

  // Storage has no reset; only words behind the pointers are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_q] <= inData;
    end
  end
endmodule : asr_fifo

module asr_rx_latch_and_clock_mux (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Wishbone slave
  input  wire logic                    wbCyc,
  input  wire logic                    wbStb,
  input  wire logic                    wbWe,
  input  wire logic [asr_pkg::ADR_W-1:0] wbAdr,
  input  wire logic [3:0]              wbSel,
  input  wire logic [31:0]             wbDatW,
  output logic      [31:0]             wbDatR,
  output logic                         wbAck,
  // Serial pins
  input  wire logic                    extBitclk,
  input  wire logic                    extFrame,
  input  wire logic                    priDataPin,
  input  wire logic                    secDataPin,
  // Internal dividers and port setup
  input  wire logic                    intBitclk,
  input  wire logic                    intFrame,
  input  wire logic                    controllerMode,
  input  wire logic                    bitclkPolarity,
  input  wire logic                    fmtTdm,
  // Clock source selects
  output logic      [1:0]              pllPredivSource,
  output logic      [2:0]              priBitclkDividerSource,
  output logic      [2:0]              secBitclkDividerSource,
  // Received words: secondary pin high half, primary pin low half
  output logic                         rxValid,
  input  wire logic                    rxReady,
  output logic      [63:0]             rxData
);
  import asr_pkg::*;

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [7:0]  rxCfg_q, rxCfg_d, clkSrc_q, clkSrc_d, secSrc_q, secSrc_d;
  logic        ack_q, ack_d, overrun_q, overrun_d;
  logic [31:0] datR_q, datR_d;
  logic [7:0]  idx;
  logic        req, wrLane0, overrunSet;
  asr_rx_e     state_q;

  assign idx     = wbAdr[ADR_W-1:2];
  assign req     = wbCyc && wbStb && !ack_q;
  assign wrLane0 = req && wbWe && wbSel[0];

  always_comb begin
    rxCfg_d   = rxCfg_q;
    clkSrc_d  = clkSrc_q;
    secSrc_d  = secSrc_q;
    ack_d     = req;
    datR_d    = 32'h0000_0000;
    overrun_d = overrun_q;
    if (wrLane0 && idx == IDX_SEC_RX_CFG) begin
      rxCfg_d = wbDatW[7:0];
    end
    if (wrLane0 && idx == IDX_CLK_SRC) begin
      clkSrc_d = {wbDatW[7:3], 3'h0}; // R8
    end
    if (wrLane0 && idx == IDX_SEC_BCLK_SRC) begin
      secSrc_d = {1'b0, wbDatW[6:4], 4'h0};
    end
    if (wrLane0 && idx == IDX_RX_STATUS && wbDatW[ST_OVERRUN_BIT]) begin
      overrun_d = 1'b0;
    end
    // Set beats a clear in the same cycle
    if (overrunSet) begin
      overrun_d = 1'b1;
    end
    if (req && !wbWe) begin
      case (idx)
        IDX_SEC_RX_CFG:   datR_d = {24'h00_0000, rxCfg_q};
        IDX_CLK_SRC:      datR_d = {24'h00_0000, clkSrc_q}; // R8
        IDX_SEC_BCLK_SRC: datR_d = {24'h00_0000, secSrc_q};
        IDX_RX_STATUS:    datR_d = {29'h0000_0000, state_q != RX_IDLE, rxValid, overrun_q};
        default:          datR_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxCfg_q   <= RST_SEC_RX_CFG;
      clkSrc_q  <= RST_CLK_SRC;
      secSrc_q  <= RST_SEC_BCLK_SRC;
      ack_q     <= 1'b0;
      datR_q    <= 32'h0000_0000;
      overrun_q <= 1'b0;
    end else begin
      rxCfg_q   <= rxCfg_d;
      clkSrc_q  <= clkSrc_d;
      secSrc_q  <= secSrc_d;
      ack_q     <= ack_d;
      datR_q    <= datR_d;
      overrun_q <= overrun_d;
    end
  end

  assign wbAck                  = ack_q;
  assign wbDatR                 = datR_q;
  assign pllPredivSource        = clkSrc_q[PREDIV_MSB:PREDIV_LSB]; // R6
  assign priBitclkDividerSource = clkSrc_q[PRIDIV_MSB:PRIDIV_LSB]; // R7
  assign secBitclkDividerSource = secSrc_q[SECDIV_MSB:SECDIV_LSB];

  // ----------------------------------------------------------------
  // Pin synchronisers and clock selection
  // ----------------------------------------------------------------
  logic [3:0] pinS1_q, pinS2_q;
  logic       bPrev_q, bPrev_d, fPrev_q, fPrev_d;
  logic       selB, selF, latchOnRise, latchEv, frameStart;
  logic [4:0] offset;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinS1_q <= 4'h0;
      pinS2_q <= 4'h0;
    end else begin
      pinS1_q <= {secDataPin, priDataPin, extFrame, extBitclk};
      pinS2_q <= pinS1_q;
    end
  end

  assign offset = rxCfg_q[RX_OFS_MSB:RX_OFS_LSB];

  always_comb begin
    selB = (controllerMode && rxCfg_q[RX_INT_BCLK_BIT]) ? intBitclk : pinS2_q[0]; // R3
    selF = (controllerMode && rxCfg_q[RX_INT_FRAME_BIT]) ? intFrame : pinS2_q[1]; // R2
    // Edge bit moves latching half a bitclock later
    latchOnRise = !(bitclkPolarity ^ rxCfg_q[RX_EDGE_BIT]); // R1
    latchEv     = latchOnRise ? (selB && !bPrev_q) : (!selB && bPrev_q); // R1
    // I2S and LJ restart on both frame edges, TDM on the rising one
    frameStart  = latchEv && (fmtTdm ? (selF && !fPrev_q) : (selF != fPrev_q)); // R5
    bPrev_d     = selB;
    fPrev_d     = latchEv ? selF : fPrev_q;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bPrev_q <= 1'b0;
      fPrev_q <= 1'b0;
    end else begin
      bPrev_q <= bPrev_d;
      fPrev_q <= fPrev_d;
    end
  end

  // ----------------------------------------------------------------
  // Slot 0 capture
  // ----------------------------------------------------------------
  asr_rx_e     state_d;
  logic [4:0]  skip_q, skip_d, bitCnt_q, bitCnt_d;
  logic [31:0] shPri_q, shPri_d, shSec_q, shSec_d;
  logic        push_q, push_d, fifoReady;
  logic [63:0] word_q, word_d;
  logic        capture;

  always_comb begin
    state_d  = state_q;
    skip_d   = skip_q;
    bitCnt_d = bitCnt_q;
    capture  = 1'b0;
    push_d   = 1'b0;
    word_d   = word_q;
    if (frameStart) begin
      bitCnt_d = 5'h00;
      if (offset == 5'h00) begin
        capture = 1'b1;
        state_d = RX_SHIFT;
        bitCnt_d = 5'h01;
      end else begin
        state_d = RX_SKIP; // R4
        skip_d  = offset - 5'h01; // R4
      end
    end else if (latchEv) begin
      case (state_q)
        RX_SKIP: begin
          if (skip_q == 5'h00) begin
            capture  = 1'b1;
            state_d  = RX_SHIFT;
            bitCnt_d = 5'h01;
          end else begin
            skip_d = skip_q - 5'h01; // R4
          end
        end
        RX_SHIFT: begin
          capture  = 1'b1;
          bitCnt_d = bitCnt_q + 5'h01;
          if (bitCnt_q == LAST_BIT) begin
            state_d = RX_IDLE;
            push_d  = 1'b1;
          end
        end
        default: state_d = RX_IDLE;
      endcase
    end
    shPri_d = capture ? {shPri_q[30:0], pinS2_q[2]} : shPri_q; // R5
    shSec_d = capture ? {shSec_q[30:0], pinS2_q[3]} : shSec_q; // R5
    if (push_d) begin
      word_d = {shSec_d, shPri_d};
    end
  end

  // A full FIFO drops the word and flags it; the link cannot be paused
  assign overrunSet = push_q && !fifoReady;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q  <= RX_IDLE;
      skip_q   <= 5'h00;
      bitCnt_q <= 5'h00;
      shPri_q  <= 32'h0000_0000;
      shSec_q  <= 32'h0000_0000;
      push_q   <= 1'b0;
      word_q   <= 64'h0000_0000_0000_0000;
    end else begin
      state_q  <= state_d;
      skip_q   <= skip_d;
      bitCnt_q <= bitCnt_d;
      shPri_q  <= shPri_d;
      shSec_q  <= shSec_d;
      push_q   <= push_d;
      word_q   <= word_d;
    end
  end

  asr_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) uFifo (
    .clock    (clock),
    .nrst     (nrst),
    .inValid  (push_q),
    .inReady  (fifoReady),
    .inData   (word_q),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxData)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  ack_single_a: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("ack not one cycle after request");
  latch_edge_a: assert property (latchEv |-> selB == latchOnRise && bPrev_q != selB) // R1
    else $error("latch on wrong bitclock edge");
  frame_select_a: assert property (controllerMode && rxCfg_q[RX_INT_FRAME_BIT]
                                   |-> selF == intFrame) // R2
    else $error("internal frame sync not selected");
  bitclk_select_a: assert property (!(controllerMode && rxCfg_q[RX_INT_BCLK_BIT])
                                    |-> selB == pinS2_q[0]) // R3
    else $error("external bitclock not selected");
  offset_skip_a: assert property (frameStart && offset != 5'h00
                                  |=> state_q == RX_SKIP && skip_q == $past(offset) - 5'h01) // R4
    else $error("offset skip count wrong");
  both_slots_a: assert property (!fmtTdm && latchEv && selF != fPrev_q |-> frameStart) // R5
    else $error("right slot 0 not restarted");
  prediv_write_a: assert property (wrLane0 && idx == IDX_CLK_SRC
                                   |=> pllPredivSource == $past(wbDatW[7:6])) // R6
    else $error("pre-divider source not updated");
  pridiv_write_a: assert property (wrLane0 && idx == IDX_CLK_SRC
                                   |=> priBitclkDividerSource == $past(wbDatW[5:3])) // R7
    else $error("primary divider source not updated");
  resv_zero_a: assert property (wbAck && !wbWe && idx == IDX_CLK_SRC |-> wbDatR[2:0] == 3'h0) // R8
    else $error("reserved clock bits not zero");
  overrun_set_a: assert property (overrunSet |=> overrun_q)
    else $error("overrun lost");

  word_pushed_c: cover property (push_q && fifoReady);
  offset_used_c: cover property (state_q == RX_SKIP ##[1:200] state_q == RX_SHIFT);
  overrun_c: cover property (overrunSet);
  internal_clk_c: cover property (controllerMode && rxCfg_q[RX_INT_BCLK_BIT] && latchEv);
endmodule : asr_rx_latch_and_clock_mux
`default_nettype wire

// ---- asr_host_link.sv ----
// Behavioural audio host that sends serial frames into the receiver
`timescale 1ns/10ps
`default_nettype none
module asr_host_link #(
  parameter int HALF = 4
) (
  // Clock
  input  wire logic clock,
  // Link setup
  input  wire logic latchFall,
  input  wire logic tdm,
  // Serial lines
  output logic      bclk,
  output logic      frame,
  output logic      priDat,
  output logic      secDat
);
  initial begin
    bclk = 1'b0;
    frame = 1'b0;
    priDat = 1'b0;
    secDat = 1'b1;
  end
  // ----
  // Half frame: n filler bits, then one word per pin, MSB first
  // ----
  task automatic sendHalf(input logic [31:0] p, input logic [31:0] s, input int n);
    int i;
    @(posedge clock);
    bclk <= latchFall;
    repeat (HALF) @(posedge clock);
    // Lines move on the far edge, so a latch on the wrong edge shifts the word
    for (i = 0; i < n + 32; i++) begin
      bclk <= latchFall;
      frame <= tdm ? (i == 0) : ((i == 0) ^ frame);
      priDat <= (i < n) ? ~priDat : p[31 + n - i];
      secDat <= (i < n) ? ~secDat : s[31 + n - i];
      repeat (HALF) @(posedge clock);
      bclk <= ~latchFall;
      repeat (HALF) @(posedge clock);
    end
    bclk <= latchFall;
    // Released lines flip, so a late sample cannot pass
    priDat <= ~priDat;
    secDat <= ~secDat;
  endtask : sendHalf
endmodule : asr_host_link
`default_nettype wire

// ---- asr_rx_latch_and_clock_mux_test.sv ----
// Self-checking bench for the secondary receive latch and clock source block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module asr_rx_latch_and_clock_mux_test;
  import asr_pkg::*;
  logic             clock, nrst, wbCyc, wbStb, wbWe, wbAck, rxValid, rxReady, hold;
  logic             pBclk, pFrame, pPri, pSec, rtB, rtF;
  logic [ADR_W-1:0] wbAdr;
  logic [3:0]       wbSel;
  logic [31:0]      wbDatW, wbDatR, rd;
  logic [1:0]       pre;
  logic [2:0]       priSrc, secSrc;
  logic [63:0]      rxData, want;
  logic [10:0]      cur;
  logic [63:0]      exp[$];
  int               num_errors = 0;
  int               compares = 0;
  int               seed = 29408;
  int               k, c;
  // Case word: controller, polarity, tdm, receive config byte
  logic [10:0] cases [6] = '{11'h100, 11'h19F, 11'h661, 11'h7C3, 11'h422, 11'h160};
  assign rtB = cur[10] & cur[5];
  assign rtF = cur[10] & cur[6];
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  asr_rx_latch_and_clock_mux asr_rx_latch_and_clock_mux_inst (
    .clock(clock), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .extBitclk(rtB ? 1'b0 : pBclk), .extFrame(rtF ? 1'b0 : pFrame),
    .priDataPin(pPri), .secDataPin(pSec),
    .intBitclk(rtB ? pBclk : 1'b0), .intFrame(rtF ? pFrame : 1'b0),
    .controllerMode(cur[10]), .bitclkPolarity(cur[9]), .fmtTdm(cur[8]),
    .pllPredivSource(pre), .priBitclkDividerSource(priSrc),
    .secBitclkDividerSource(secSrc),
    .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData));
  asr_host_link #(.HALF(4)) asr_host_link_inst (
    .clock(clock), .latchFall(cur[9] ^ cur[7]), .tdm(cur[8]),
    .bclk(pBclk), .frame(pFrame), .priDat(pPri), .secDat(pSec));
  // ----
  // Consumer and word model
  // ----
  always @(posedge clock) begin
    rxReady <= hold ? 1'b0 : 1'($random(seed));
    if (rxValid === 1'b1 && rxReady === 1'b1) begin
      if (exp.size() == 0) begin
        num_errors++;
        $display("ERROR %0t: unexpected word", $time);
      end else begin
        want = exp.pop_front();
        `CHK(rxData, want)
      end
    end
  end
  // ----
  // Bus and stream tasks
  // ----
  task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [7:0] d,
                    output logic [31:0] r);
    @(posedge clock);
    {wbCyc, wbStb, wbWe} <= {2'b11, we};
    wbAdr <= a;
    wbSel <= 4'h1;
    wbDatW <= {24'h0, d};
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clock);
    end while (wbAck !== 1'b1);
    r = wbDatR;
    {wbCyc, wbStb} <= 2'b00;
  endtask : wb
  task automatic rdChk(input logic [ADR_W-1:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    `CHK(r, {24'h0, e})
  endtask : rdChk
  task automatic frames(input int cnt, input int keep);
    logic [31:0] p, s;
    int i;
    for (i = 0; i < cnt; i++) begin
      p = $random(seed);
      s = $random(seed);
      if (i < keep) exp.push_back({s, p});
      asr_host_link_inst.sendHalf(p, s, int'(cur[4:0]));
    end
  endtask : frames
  task automatic drain;
    int n;
    n = 0;
    while (exp.size() != 0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
  endtask : drain
  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // ----
  // Main sequence
  // ----
  initial begin
    {nrst, wbCyc, wbStb, wbWe, hold} = 5'h00;
    wbAdr = '0;
    wbSel = 4'h1;
    wbDatW = '0;
    cur = 11'h100;
    rxReady = 1'b0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    `CHK({pre, priSrc, secSrc}, 8'h00)
    rdChk(10'h098, 8'h00);
    rdChk(10'h0C8, 8'h00);
    rdChk(10'h3FC, 8'h00);
    // Sources change only with no traffic running
    for (k = 0; k < 32; k++) begin
      if (k[2:0] == 3'h1 || k[2:0] > 3'h5) continue;
      wb(1'b1, 10'h0C8, {k[4:0], 3'h0}, rd);
      `CHK({pre, priSrc}, k[4:0])
      rdChk(10'h0C8, {k[4:0], 3'h0});
    end
    wb(1'b1, 10'h0CC, 8'hDA, rd);
    `CHK(secSrc, 3'h5)
    rdChk(10'h0CC, 8'h50);
    for (c = 0; c < 6; c++) begin
      @(posedge clock);
      cur <= cases[c];
      wb(1'b1, 10'h098, cases[c][7:0], rd);
      rdChk(10'h098, cases[c][7:0]);
      frames(2, 2);
      drain();
      `CHK(exp.size(), 0)
    end
    // Stalled consumer: sixteen plus the output stage fit, the rest is lost
    hold <= 1'b1;
    frames(18, 17);
    wb(1'b0, 10'h09C, 8'h00, rd);
    `CHK(rd[0], 1'b1)
    wb(1'b1, 10'h09C, 8'h01, rd);
    wb(1'b0, 10'h09C, 8'h00, rd);
    `CHK(rd[1:0], 2'b10)
    hold <= 1'b0;
    drain();
    `CHK(exp.size(), 0)
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    report_and_stop();
  end
endmodule : asr_rx_latch_and_clock_mux_test
`default_nettype wire
